// ### src/paged_data_memory_decoder.sv
// Top: APB slave holding the pointer and the paged data RAM behind it
`timescale 1ns/10ps
`default_nettype none
module paged_data_memory_decoder #(
    parameter int unsigned RAM_WORDS = 256
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [page_map_pkg::ADDR_W-1:0] paddr,
    input wire logic [page_map_pkg::DATA_W-1:0] pwdata,
    output logic [page_map_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [page_map_pkg::PTR_W-1:0] pointer_out,
    output logic [page_map_pkg::RAM_AW-1:0] ram_addr_out
);
    // ****************************************
    // Storage and mapping
    // ****************************************
    logic [page_map_pkg::PTR_W-1:0] indirect_address_pointer_reg;
    logic [7:0] ram [RAM_WORDS];
    logic setup;
    logic access;
    page_map_if map_bus ();
    page_addr_map u_map (
        .map(map_bus.decoder)
    );
    assign map_bus.pointer = indirect_address_pointer_reg;

    function automatic logic is_reg(input logic [page_map_pkg::ADDR_W-1:0] a);
        is_reg = (a == page_map_pkg::OFF_POINTER) || (a == page_map_pkg::OFF_DATA)
            || (a == page_map_pkg::OFF_RAM_ADDR);
    endfunction

    // Ready is registered from the setup phase: no wait states per access, keeps outputs flop-driven
    assign setup = psel && !penable;
    assign access = psel && penable && pready;

    // ****************************************
    // Bus handshake
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !is_reg(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indirect_address_pointer_reg <= page_map_pkg::POINTER_RESET;
        end else if (access && pwrite && paddr == page_map_pkg::OFF_POINTER) begin
            indirect_address_pointer_reg <= pwdata[page_map_pkg::PTR_W-1:0];
        end
    end

    // No reset on the array: RAM contents are undefined at power-up
    always_ff @(posedge pclk) begin
        if (access && pwrite && paddr == page_map_pkg::OFF_DATA) begin
            ram[map_bus.ram_addr] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= page_map_pkg::DATA_ZERO;
        end else if (setup && !pwrite) begin
            case (paddr)
                page_map_pkg::OFF_POINTER: prdata <= {24'h00_0000, indirect_address_pointer_reg};
                page_map_pkg::OFF_DATA: prdata <= {24'h00_0000, ram[map_bus.ram_addr]};
                page_map_pkg::OFF_RAM_ADDR: prdata <= {24'h00_0000, map_bus.ram_addr};
                default: prdata <= page_map_pkg::DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pointer_out <= page_map_pkg::POINTER_RESET;
            ram_addr_out <= 8'h00;
        end else begin
            pointer_out <= indirect_address_pointer_reg;
            ram_addr_out <= map_bus.ram_addr;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    shared_lower_a: assert property (!map_bus.pointer[4] |-> map_bus.ram_addr[7:4] == 4'h0)
        else $error("Lower half not mapped to page 0");
    upper_half_a: assert property (map_bus.pointer[4] |-> map_bus.ram_addr[4])
        else $error("Upper half bit lost");
    page_select_a: assert property (map_bus.pointer[4] |-> map_bus.ram_addr[7:5] == map_bus.pointer[7:5])
        else $error("Page bits not routed");
    byte_select_a: assert property (map_bus.ram_addr[3:0] == map_bus.pointer[3:0])
        else $error("Byte select mismatch");
    offset_direct_a: assert property (map_bus.pointer[3:0] == 4'hC |-> map_bus.ram_addr[3:0] == 4'hC)
        else $error("Offset not direct");
    page_ignored_a: assert property (!map_bus.pointer[4] |-> map_bus.ram_addr == {4'h0, map_bus.pointer[3:0]})
        else $error("Page bits leaked into lower half");
    addr_out_a: assert property (##1 ram_addr_out == $past(map_bus.ram_addr))
        else $error("Registered RAM address stale");
    ready_wait_a: assert property (setup |=> pready ##1 !pready)
        else $error("Ready timing wrong");

    pointer_write_c: cover property (access && pwrite && paddr == page_map_pkg::OFF_POINTER);
    data_read_c: cover property (access && !pwrite && paddr == page_map_pkg::OFF_DATA);
    upper_page_c: cover property (map_bus.pointer[4] && map_bus.pointer[7:5] == 3'h7);
    refused_c: cover property (pready && pslverr);
    // Lower-half write from a nonzero page must still land in the shared bytes
    mirror_write_c: cover property (access && pwrite && paddr == page_map_pkg::OFF_DATA && !map_bus.dependent
        && map_bus.pointer[page_map_pkg::PAGE_HI:page_map_pkg::PAGE_LO] != page_map_pkg::PAGE_ZERO);
endmodule
`default_nettype wire

// ### pkg/page_map_pkg.sv
// Package: register offsets, field layout and reset values of the paged data memory decoder
package page_map_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PTR_W = 8;
    localparam int unsigned RAM_AW = 8;
    localparam int unsigned BYTE_LO = 0;
    localparam int unsigned BYTE_HI = 3;
    localparam int unsigned DEP_BIT = 4;
    localparam int unsigned PAGE_LO = 5;
    localparam int unsigned PAGE_HI = 7;
    localparam int unsigned PAGE_W = 3;
    localparam int unsigned BYTE_W = 4;
    localparam logic [ADDR_W-1:0] OFF_POINTER = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_DATA = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_RAM_ADDR = 12'h008;
    localparam logic [PTR_W-1:0] POINTER_RESET = 8'h00;
    localparam logic [PAGE_W-1:0] PAGE_ZERO = 3'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
endpackage

// ### pkg/page_map_if.sv
// Interface: pointer in, physical RAM address out
`timescale 1ns/10ps
`default_nettype none
interface page_map_if;
    logic [page_map_pkg::PTR_W-1:0] pointer;
    logic [page_map_pkg::RAM_AW-1:0] ram_addr;
    logic dependent;
    modport decoder (input pointer, output ram_addr, output dependent);
    modport user (output pointer, input ram_addr, input dependent);
endinterface
`default_nettype wire

// ### src/page_addr_map.sv
// Combinational pointer-to-RAM address mapping
`timescale 1ns/10ps
`default_nettype none
module page_addr_map (
    page_map_if.decoder map
);
    logic [page_map_pkg::PAGE_W-1:0] page;
    logic [page_map_pkg::BYTE_W-1:0] byte_sel;
    always_comb begin
        byte_sel = map.pointer[page_map_pkg::BYTE_HI:page_map_pkg::BYTE_LO];
        map.dependent = map.pointer[page_map_pkg::DEP_BIT];
        // Lower half ignores page bits, so every page sees page 0 storage
        if (map.dependent) begin
            page = map.pointer[page_map_pkg::PAGE_HI:page_map_pkg::PAGE_LO];
        end else begin
            page = page_map_pkg::PAGE_ZERO;
        end
        map.ram_addr = {page, map.dependent, byte_sel};
    end
endmodule
`default_nettype wire

// ### verif/core_model.sv
// Core model: APB master issuing indirect data memory accesses
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [page_map_pkg::ADDR_W-1:0] paddr,
    output logic [page_map_pkg::DATA_W-1:0] pwdata,
    input wire logic [page_map_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = page_map_pkg::OFF_POINTER;
        pwdata = page_map_pkg::DATA_ZERO;
    end
    // Request held until pready is seen high; one idle edge follows
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            tb.n_fail++;
            tb.summarize();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// Testbench: pointer decode, mirrored lower half, unique upper halves
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [page_map_pkg::ADDR_W-1:0] paddr;
    logic [page_map_pkg::DATA_W-1:0] pwdata, prdata, q;
    logic [7:0] pointer_out, ram_addr_out, p, e;
    int n_fail = 0;
    int num_checks = 0;
    initial forever #50 pclk = ~pclk;
    paged_data_memory_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pointer_out(pointer_out), .ram_addr_out(ram_addr_out));
    core_model core_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({24'h00_0000, ram_addr_out}, page_map_pkg::DATA_ZERO);
        // Every pointer value; lower-half writes overwrite each other, page 7 last
        for (int i = 0; i < 256; i++) begin
            p = i[7:0];
            e = {p[4] ? p[7:5] : 3'h0, p[4], p[3:0]};
            core_u.xfer(1'b1, page_map_pkg::OFF_POINTER, {24'h00_0000, p}, q);
            core_u.xfer(1'b0, page_map_pkg::OFF_RAM_ADDR, page_map_pkg::DATA_ZERO, q);
            chk(q, {24'h00_0000, e});
            chk({24'h00_0000, ram_addr_out}, {24'h00_0000, e});
            chk({24'h00_0000, pointer_out}, {24'h00_0000, p});
            core_u.xfer(1'b1, page_map_pkg::OFF_DATA, {24'h00_0000, p ^ 8'hA5}, q);
        end
        for (int i = 0; i < 256; i++) begin
            p = i[7:0];
            e = p[4] ? (p ^ 8'hA5) : ({4'hE, p[3:0]} ^ 8'hA5);
            core_u.xfer(1'b1, page_map_pkg::OFF_POINTER, {24'h00_0000, p}, q);
            core_u.xfer(1'b0, page_map_pkg::OFF_DATA, page_map_pkg::DATA_ZERO, q);
            chk(q, {24'h00_0000, e});
        end
        // Unmapped word is refused
        core_u.xfer(1'b0, 12'h00C, page_map_pkg::DATA_ZERO, q);
        chk(q, page_map_pkg::DATA_ZERO);
        chk({31'h0000_0000, core_u.err}, 32'h0000_0001);
        // Refused write must leave the pointer alone (last written value 0xFF)
        core_u.xfer(1'b1, 12'h00C, page_map_pkg::DATA_ZERO, q);
        chk({31'h0000_0000, core_u.err}, 32'h0000_0001);
        core_u.xfer(1'b0, page_map_pkg::OFF_POINTER, page_map_pkg::DATA_ZERO, q);
        chk(q, 32'h0000_00FF);
        summarize();
    end
endmodule
`default_nettype wire
